/* swwc_sleep_ctrl.v */
// sleep, wake-up and watchdog control with its apb register file
`timescale 1ns/1ns
`include "swwc_defs.vh"

module swwc_sleep_ctrl #(
  parameter WDT_CYCLES = `SWWC_WDT_CYCLES,  // clock cycles per nominal timeout
  parameter PORT_W     = 8                  // port pins held in sleep
) (
  input  wire              clk_sys,        // 250 MHz system clock
  input  wire              reset_n,        // asynchronous reset, active low
  input  wire              psel,           // apb select
  input  wire              penable,        // apb access phase
  input  wire              pwrite,         // apb direction
  input  wire [15:0]       paddr,          // apb byte address
  input  wire [31:0]       pwdata,         // apb write data
  output reg  [31:0]       prdata,         // apb read data
  output reg               pready,         // apb ready
  output reg               pslverr,        // apb error, unmapped address
  input  wire              sleepInstr,     // core executes sleep, one cycle
  input  wire              wdtClearInstr,  // core executes watchdog clear, one cycle
  input  wire              instrDone,      // core finished an instruction, pulse
  input  wire [12:0]       pcIn,           // address of the sleep instruction
  input  wire              globalIrqEn,    // core global interrupt enable
  input  wire [8:0]        irqFlag,        // ext pin, port change, 7 wake peripherals
  input  wire              masterClearN,   // master clear pin, active low
  input  wire [7:0]        configWord,     // configuration fuses
  input  wire [PORT_W-1:0] portOutIn,      // core port drive levels
  input  wire [PORT_W-1:0] portOeIn,       // core port enables
  output wire [PORT_W-1:0] portOut,        // held port drive levels
  output wire [PORT_W-1:0] portOe,         // held port enables
  output reg               oscDriverEn,    // main oscillator driver on
  output reg               phaseClkEn,     // internal phase clocks run
  output reg               deviceReset,    // full device reset pulse
  output reg               wakeUp,         // resume execution pulse
  output reg  [12:0]       prefetchAddr,   // address prefetched by sleep
  output reg               prefetchValid,  // prefetch address valid
  output reg               vectorReq,      // branch to vector pulse
  output reg  [12:0]       vectorAddr      // branch target
);

  // one-hot sleep states
  localparam [3:0] ST_RUN   = 4'b0001;
  localparam [3:0] ST_SLEEP = 4'b0010;
  localparam [3:0] ST_NEXT  = 4'b0100;
  localparam [3:0] ST_VEC   = 4'b1000;

  reg        rstMetaQ;
  reg        rstSyncQ;
  reg        cfgCapQ;
  reg [7:0]  configQ;
  reg [7:0]  optionQ;
  reg [8:0]  wakeEnQ;
  reg        pdFlagQ;
  reg        toFlagQ;
  reg [3:0]  stateQ;
  reg [3:0]  stateD;
  reg [6:0]  postQ;
  reg        mclrQ;
  reg        wdtClear;
  reg        wdtTimeout;
  reg [31:0] rdData;
  reg        rdOk;

  wire       wdtTick;
  wire       wdtEn;
  wire       assignWdt;
  wire [2:0] rate;
  wire [6:0] postMask;
  wire       pending;
  wire       sleepGo;
  wire       busWr;
  wire       busSetup;
  wire       wdtRunReset;

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  // only the second flop feeds the design, so a slow release never splits it
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstSyncQ <= rstMetaQ;
    end
  end

  // fuses are caught once after release, like a strap
  // later changes on the fuse pins are ignored until the next reset
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      cfgCapQ <= 1'b0;
      configQ <= 8'h00;
    end else if (!cfgCapQ) begin
      cfgCapQ <= 1'b1;
      configQ <= configWord;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded controls
  // the fuse counts only once captured, so no timeout can fire during release
  assign wdtEn     = configQ[`SWWC_CFG_WDT_EN_BIT] & cfgCapQ;
  assign assignWdt = optionQ[`SWWC_OPT_ASSIGN_BIT];
  assign rate      = optionQ[`SWWC_OPT_RATE_HI:`SWWC_OPT_RATE_LO];
  // two to the n minus one: postscaler terminal count, n up to 7 gives 1:128
  assign postMask  = (7'h7f >> (3'd7 - rate));
  // only enabled sources count; global enable is ignored here
  assign pending   = |(irqFlag & wakeEnQ);
  assign sleepGo   = sleepInstr && stateQ == ST_RUN && !pending;

  //////////////////////////////////////////////////////////////////////////////
  // watchdog base period
  swwc_wdt_base #(
    .PERIOD (WDT_CYCLES)
  ) uWdtBase (
    .clk    (clk_sys),
    .rstN   (rstSyncQ),
    .clear  (wdtClear),
    .enable (wdtEn),
    .tick   (wdtTick)
  );

  // clear from the clear instruction while running or from an executed sleep at its entry
  always @* begin
    wdtClear = (wdtClearInstr && stateQ == ST_RUN) || sleepGo;
  end

  // postscaler: counts base ticks when assigned, else every tick times out
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      postQ <= 7'h00;
    end else if (wdtClear || !assignWdt) begin
      postQ <= 7'h00;
    end else if (wdtTick) begin
      // >= so that a rate lowered mid-count still ends at the next tick
      postQ <= (postQ >= postMask) ? 7'h00 : postQ + 7'h01;
    end
  end

  // a clear in the same cycle as the final tick wins over the timeout
  always @* begin
    wdtTimeout = wdtTick && !wdtClear && (!assignWdt || postQ >= postMask);
  end

  // the same timeout restarts a running device instead of waking it
  assign wdtRunReset = wdtTimeout && stateQ != ST_SLEEP;

  //////////////////////////////////////////////////////////////////////////////
  // master clear pin, sampled once
  // a plain level with no filter; a glitch of one cycle is a full reset
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      mclrQ <= 1'b0;
    end else begin
      mclrQ <= !masterClearN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sleep state machine next state
  always @* begin
    stateD = stateQ;
    case (stateQ)
      ST_RUN: begin
        if (sleepGo) begin
          stateD = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wdtTimeout || pending) begin
          stateD = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (instrDone) begin
          stateD = globalIrqEn ? ST_VEC : ST_RUN;
        end
      end
      ST_VEC: begin
        // one cycle to issue the branch, then back to running
        stateD = ST_RUN;
      end
      default: begin
        // an illegal one-hot code recovers to running
        stateD = ST_RUN;
      end
    endcase
  end

  // state register; master clear or a running timeout restarts the device
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      stateQ <= ST_RUN;
    end else if (mclrQ || wdtRunReset) begin
      stateQ <= ST_RUN;
    end else begin
      stateQ <= stateD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-down and timeout flags
  // a timeout never meets an executed sleep: the sleep clears the watchdog
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      pdFlagQ <= 1'b1;
      toFlagQ <= 1'b1;
    end else if (wdtTimeout && stateQ == ST_SLEEP) begin
      toFlagQ <= 1'b0;
    end else if (wdtTimeout && !mclrQ) begin
      pdFlagQ <= 1'b1;
      toFlagQ <= 1'b0;
    end else if (sleepGo && !mclrQ) begin
      pdFlagQ <= 1'b0;
      toFlagQ <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core-facing outputs, all registered
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      oscDriverEn   <= 1'b1;
      phaseClkEn    <= 1'b1;
      deviceReset   <= 1'b0;
      wakeUp        <= 1'b0;
      prefetchAddr  <= 13'h0000;
      prefetchValid <= 1'b0;
      vectorReq     <= 1'b0;
      vectorAddr    <= `SWWC_IRQ_VECTOR;
    end else begin
      // oscillator and phase clocks stop while asleep
      oscDriverEn <= (stateD != ST_SLEEP) || mclrQ;
      phaseClkEn  <= (stateD != ST_SLEEP) || mclrQ;
      deviceReset <= mclrQ || wdtRunReset;
      wakeUp      <= !mclrQ && stateQ == ST_SLEEP && stateD == ST_NEXT;
      vectorReq   <= !mclrQ && stateQ == ST_NEXT && stateD == ST_VEC;
      vectorAddr  <= `SWWC_IRQ_VECTOR;
      // a restart drops the prefetched word so it is never run later, except a master clear in the same cycle as a sleep
      if (sleepGo) begin
        prefetchAddr  <= pcIn + 13'h0001;
        prefetchValid <= 1'b1;
      end else if (mclrQ || wdtRunReset || stateQ == ST_VEC ||
                   (stateQ == ST_NEXT && instrDone)) begin
        prefetchValid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // port hold while asleep
  // hold follows the registered state, so the sleep edge itself still captures
  swwc_io_hold #(
    .WIDTH  (PORT_W)
  ) uIoHold (
    .clk    (clk_sys),
    .rstN   (rstSyncQ),
    .hold   (stateQ == ST_SLEEP),
    .outIn  (portOutIn),
    .oeIn   (portOeIn),
    .outPin (portOut),
    .oePin  (portOe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: ready rises in the access phase, so every transfer has no wait
  assign busSetup = psel && !penable;
  assign busWr    = psel && penable && pready && pwrite;

  // read mux; unmapped addresses answer with an error
  always @* begin
    rdData = 32'h0;
    rdOk   = 1'b1;
    case (paddr)
      `SWWC_ADDR_OPTION:    rdData = {24'h0, optionQ};
      `SWWC_ADDR_CONFIG:    rdData = {24'h0, configQ};
      `SWWC_ADDR_WAKE_EN:   rdData = {23'h0, wakeEnQ};
      `SWWC_ADDR_STATUS: begin
        rdData[`SWWC_ST_TO_BIT]     = toFlagQ;
        rdData[`SWWC_ST_PD_BIT]     = pdFlagQ;
        rdData[`SWWC_ST_ASLEEP_BIT] = (stateQ == ST_SLEEP);
      end
      `SWWC_ADDR_WDT_COUNT: rdData = {25'h0, postQ};
      default:              rdOk   = 1'b0;
    endcase
  end

  // answer registered at the setup edge, held through the access phase
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (busSetup) begin
      pready  <= 1'b1;
      pslverr <= !rdOk;
      prdata  <= pwrite ? 32'h0 : rdData;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
  end

  // writable registers; config and status are read-only
  // a write lands at the access edge, the one at which pready is high
  always @(posedge clk_sys or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      optionQ <= `SWWC_OPTION_RESET;
      wakeEnQ <= `SWWC_WAKE_EN_RESET;
    end else if (busWr && !pslverr) begin
      if (paddr == `SWWC_ADDR_OPTION) begin
        optionQ <= pwdata[7:0];
      end
      if (paddr == `SWWC_ADDR_WAKE_EN) begin
        wakeEnQ <= pwdata[8:0];
      end
    end
  end

endmodule

/* swwc_defs.vh */
// register map, field positions, reset values and timing for the sleep/watchdog block
`ifndef SWWC_DEFS_VH
`define SWWC_DEFS_VH

// register indices; byte address is four times the index
`define SWWC_IDX_OPTION      12'h081
`define SWWC_IDX_CONFIG      16'h2007
`define SWWC_IDX_WAKE_EN     12'h090
`define SWWC_IDX_STATUS      12'h091
`define SWWC_IDX_WDT_COUNT   12'h092
`define SWWC_ADDR_OPTION     16'h0204
`define SWWC_ADDR_CONFIG     16'h801c
`define SWWC_ADDR_WAKE_EN    16'h0240
`define SWWC_ADDR_STATUS     16'h0244
`define SWWC_ADDR_WDT_COUNT  16'h0248

// option_control fields
`define SWWC_OPT_ASSIGN_BIT  3
`define SWWC_OPT_RATE_HI     2
`define SWWC_OPT_RATE_LO     0
`define SWWC_OPTION_RESET    8'hff

// device_configuration_word fields
`define SWWC_CFG_WDT_EN_BIT  2

// status fields
`define SWWC_ST_PD_BIT       3
`define SWWC_ST_TO_BIT       4
`define SWWC_ST_ASLEEP_BIT   0
`define SWWC_WAKE_EN_RESET   9'h000

// wake source bit positions inside the wake enable / flag vectors
`define SWWC_SRC_EXT_PIN     0
`define SWWC_SRC_PORT_CHG    1
`define SWWC_SRC_COUNT       9

// interrupt vector and timing
`define SWWC_IRQ_VECTOR      13'h0004
`define SWWC_CLK_MHZ         250
`define SWWC_WDT_PERIOD_US   18000
`define SWWC_WDT_CYCLES      (`SWWC_WDT_PERIOD_US * `SWWC_CLK_MHZ)
`define SWWC_POST_MAX_LOG2   7

`endif

/* swwc_wdt_base.v */
// watchdog base period divider: one-cycle tick each nominal period
`timescale 1ns/1ns
module swwc_wdt_base #(
  parameter PERIOD = 4500000  // clock cycles per nominal period
) (
  input  wire        clk,     // system clock
  input  wire        rstN,    // synchronised reset, active low
  input  wire        clear,   // restart the period
  input  wire        enable,  // watchdog enabled by fuse
  output reg         tick     // one-cycle pulse at period end
);

  reg [31:0] countQ;

  //////////////////////////////////////////////////////////////////////////////
  // free-running count; a clear restarts it without stopping it
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      countQ <= 32'h0;
      tick   <= 1'b0;
    end else if (clear || !enable) begin
      countQ <= 32'h0;
      tick   <= 1'b0;
    end else if (countQ == PERIOD - 1) begin
      countQ <= 32'h0;
      tick   <= 1'b1;
    end else begin
      countQ <= countQ + 32'h1;
      tick   <= 1'b0;
    end
  end

endmodule

/* swwc_io_hold.v */
// per-pin output hold: freezes drive level and enable while asleep
`timescale 1ns/1ns
module swwc_io_hold #(
  parameter WIDTH = 8  // number of port pins
) (
  input  wire             clk,     // system clock
  input  wire             rstN,    // synchronised reset, active low
  input  wire             hold,    // high while in power-down
  input  wire [WIDTH-1:0] outIn,   // core drive level
  input  wire [WIDTH-1:0] oeIn,    // core output enable
  output wire [WIDTH-1:0] outPin,  // pin drive level, from flop
  output wire [WIDTH-1:0] oePin    // pin output enable, from flop
);

  genvar i;

  //////////////////////////////////////////////////////////////////////////////
  // each pin keeps high, low or released exactly as before sleep
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gPin
      reg outQ;
      reg oeQ;
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          outQ <= 1'b0;
          oeQ  <= 1'b0;
        end else if (!hold) begin
          outQ <= outIn[i];
          oeQ  <= oeIn[i];
        end
      end
      assign outPin[i] = outQ;
      assign oePin[i]  = oeQ;
    end
  endgenerate

endmodule

/* swwc_core_model.sv */
// core model: runs the prefetched instruction after each wake-up
`timescale 1ns/1ns
module swwc_core_model (
  input  wire       clk_sys,   // system clock
  input  wire [3:0] lat,       // cycles taken by the post-sleep instruction
  input  wire       wakeUp,    // resume pulse from the block
  output reg        instrDone  // post-sleep instruction finished
);
  int cnt = 0;
  initial instrDone = 1'b0;
  // a countdown rather than a fixed delay, so both prompt and slow cores are exercised
  always @(posedge clk_sys) begin
    instrDone <= 1'b0;
    if (wakeUp === 1'b1) begin
      cnt <= lat;
    end else if (cnt == 1) begin
      instrDone <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* swwc_sleep_ctrl_sva.sv */
// checker for the sleep and watchdog block, watching its ports only
`timescale 1ns/1ns
module swwc_sleep_chk #(
  parameter WDT_CYCLES = 20,  // clock cycles per nominal timeout
  parameter PORT_W     = 8    // port pins held in sleep
) (
  input wire              clk_sys,        // system clock
  input wire              reset_n,        // reset, active low
  input wire              psel,           // apb select
  input wire              penable,        // apb access phase
  input wire              pready,         // apb ready
  input wire              pslverr,        // apb error
  input wire [12:0]       pcIn,           // sleep instruction address
  input wire              globalIrqEn,    // global interrupt enable
  input wire              instrDone,      // post-sleep instruction done
  input wire              masterClearN,   // master clear pin
  input wire [PORT_W-1:0] portOut,        // held port levels
  input wire [PORT_W-1:0] portOe,         // held port enables
  input wire              oscDriverEn,    // oscillator driver on
  input wire              phaseClkEn,     // phase clocks run
  input wire              deviceReset,    // device reset pulse
  input wire              wakeUp,         // wake pulse
  input wire [12:0]       prefetchAddr,   // prefetched address
  input wire              prefetchValid,  // prefetch valid
  input wire              vectorReq,      // branch to vector
  input wire [12:0]       vectorAddr      // branch target
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  a_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_sleep_entry: assert property ($rose(prefetchValid) |-> !oscDriverEn && !phaseClkEn)
    else $error("clocks still on in sleep");
  a_prefetch_next: assert property ($rose(prefetchValid) |-> prefetchAddr == $past(pcIn) + 13'h1)
    else $error("wrong prefetch address");
  // three asleep samples so the boundary capture edge is never judged
  a_port_hold: assert property (!phaseClkEn && !$past(phaseClkEn) && !$past(phaseClkEn, 2)
    |-> $stable(portOut) && $stable(portOe))
    else $error("port moved while asleep");
  a_wake_clocks: assert property (wakeUp |-> oscDriverEn && phaseClkEn)
    else $error("woke with clocks off");
  a_wake_no_reset: assert property (wakeUp |-> !deviceReset)
    else $error("wake-up also reset");
  a_master_clear_pin_reset: assert property (!masterClearN |-> ##2 deviceReset)
    else $error("master clear gave no reset");
  a_vector_branch: assert property (instrDone && prefetchValid && globalIrqEn |=> vectorReq)
    else $error("no branch after wake");
  a_no_vector: assert property (instrDone && !globalIrqEn |=> !vectorReq)
    else $error("branch with global enable clear");
  a_vector_addr: assert property (vectorAddr == 13'h0004)
    else $error("wrong vector address");
  c_wake: cover property (wakeUp && !globalIrqEn);
  c_vector: cover property (vectorReq);
  c_reset: cover property (deviceReset && masterClearN);
endmodule

bind swwc_sleep_ctrl swwc_sleep_chk #(.WDT_CYCLES(WDT_CYCLES), .PORT_W(PORT_W)) chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .pcIn(pcIn), .globalIrqEn(globalIrqEn), .instrDone(instrDone),
  .masterClearN(masterClearN), .portOut(portOut), .portOe(portOe),
  .oscDriverEn(oscDriverEn), .phaseClkEn(phaseClkEn), .deviceReset(deviceReset),
  .wakeUp(wakeUp), .prefetchAddr(prefetchAddr), .prefetchValid(prefetchValid),
  .vectorReq(vectorReq), .vectorAddr(vectorAddr));

/* tb_swwc_sleep_ctrl.sv */
// self-checking bench for the sleep, wake-up and watchdog block
`timescale 1ns/1ns
`include "swwc_defs.vh"
module tb_swwc_sleep_ctrl;
  localparam int WDT = 20;  // short base period keeps the run brief
  logic        clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, sleepInstr = 1'b0, wdtClearInstr = 1'b0, instrDone;
  logic [12:0] pcIn = 13'h0, prefetchAddr, vectorAddr;
  logic        globalIrqEn = 1'b0, masterClearN = 1'b1;
  logic [8:0]  irqFlag = 9'h0;
  logic [7:0]  portOutIn = 8'h5a, portOeIn = 8'h0f, portOut, portOe, cfgWord = 8'h04;
  logic        oscDriverEn, phaseClkEn, deviceReset, wakeUp, prefetchValid, vectorReq;
  logic        sawVec = 1'b0, sawRst = 1'b0, sawWake = 1'b0;
  logic [3:0]  lat = 4'h1;
  int          mismatches = 0, cmp_count = 0, cyc = 0, n, c, lo;

  swwc_sleep_ctrl #(.WDT_CYCLES(WDT), .PORT_W(8)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepInstr(sleepInstr), .wdtClearInstr(wdtClearInstr), .instrDone(instrDone),
    .pcIn(pcIn), .globalIrqEn(globalIrqEn), .irqFlag(irqFlag), .masterClearN(masterClearN),
    .configWord(cfgWord), .portOutIn(portOutIn), .portOeIn(portOeIn), .portOut(portOut),
    .portOe(portOe), .oscDriverEn(oscDriverEn), .phaseClkEn(phaseClkEn),
    .deviceReset(deviceReset), .wakeUp(wakeUp), .prefetchAddr(prefetchAddr),
    .prefetchValid(prefetchValid), .vectorReq(vectorReq), .vectorAddr(vectorAddr));
  swwc_core_model core (.clk_sys(clk_sys), .lat(lat), .wakeUp(wakeUp), .instrDone(instrDone));

  initial forever #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // event catchers, and a ceiling well above the several hundred cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (vectorReq === 1'b1) sawVec <= 1'b1;
    if (deviceReset === 1'b1) sawRst <= 1'b1;
    if (wakeUp === 1'b1) sawWake <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // apb transfer: held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // only the bench ceiling ends a hung wait
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic clr, input logic [12:0] pc);
    @(posedge clk_sys);
    wdtClearInstr <= clr;
    sleepInstr <= !clr;
    pcIn <= pc;
    @(posedge clk_sys);
    wdtClearInstr <= 1'b0;
    sleepInstr <= 1'b0;
    #1;
  endtask
  task automatic goSleep(input logic [12:0] pc);
    pulse(1'b0, pc);
    chk({16'h0, oscDriverEn, phaseClkEn, prefetchValid, prefetchAddr}, {16'h0, 3'b001, pc + 13'h1});
  endtask
  task automatic waitWake();
    c = 0;
    while (wakeUp !== 1'b1 && c < 4000) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
  endtask
  task automatic waitRun();
    while (prefetchValid !== 1'b0) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(0, `SWWC_ADDR_OPTION, 0);
    chk(rd, 32'hff);
    apb(0, `SWWC_ADDR_STATUS, 0);
    chk(rd, 32'h18);
    apb(0, `SWWC_ADDR_WAKE_EN, 0);
    chk(rd, 32'h0);
    apb(1, `SWWC_ADDR_CONFIG, 32'h0);
    apb(0, `SWWC_ADDR_CONFIG, 0);
    chk(rd, 32'h04);
    apb(0, 16'h0300, 0);
    chk({rd[30:0], er}, 32'h1);
    // watchdog wake for rates 1, 2 and 4 base periods
    for (n = 0; n < 3; n++) begin
      apb(1, `SWWC_ADDR_OPTION, 32'h8 | n);
      pulse(1'b1, 13'h0);
      apb(0, `SWWC_ADDR_WDT_COUNT, 0);
      chk(rd, 32'h0);
      apb(0, `SWWC_ADDR_OPTION, 0);
      chk(rd, 32'h8 | n);
      goSleep(13'h040);
      waitWake();
      lo = (WDT << n) - 2;
      chk(32'(c >= lo && c <= lo + 6), 32'h1);
      apb(0, `SWWC_ADDR_STATUS, 0);
      chk(rd, 32'h0);
      waitRun();
    end
    // each wake source alone; a disabled source is raised first and must not wake
    apb(1, `SWWC_ADDR_OPTION, 32'h0f);
    for (n = 0; n < 9; n++) begin
      pulse(1'b1, 13'h0);
      apb(1, `SWWC_ADDR_WAKE_EN, 32'h1 << n);
      globalIrqEn <= n[0];
      lat <= n[3:0] + 4'h1;
      portOutIn <= 8'h5a;
      portOeIn <= 8'h0f;
      sawVec = 1'b0;
      goSleep(13'h100 + 13'(n));
      @(posedge clk_sys);
      irqFlag <= 9'h1 << ((n + 1) % 9);
      portOutIn <= 8'ha5;
      portOeIn <= 8'hf0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk({15'h0, phaseClkEn, portOe, portOut}, 32'h0f5a);
      @(posedge clk_sys);
      irqFlag <= irqFlag | (9'h1 << n);
      waitWake();
      chk(32'(c < 4), 32'h1);
      @(posedge clk_sys);
      irqFlag <= 9'h0;
      waitRun();
      chk({31'h0, sawVec}, {31'h0, n[0]});
      apb(0, `SWWC_ADDR_STATUS, 0);
      chk(rd, 32'h10);
    end
    // watchdog timeout while running resets the device
    globalIrqEn <= 1'b0;
    apb(1, `SWWC_ADDR_OPTION, 32'h08);
    pulse(1'b1, 13'h0);
    c = 0;
    while (deviceReset !== 1'b1 && c < 100) begin
      @(posedge clk_sys);
      #1;
      c++;
    end
    chk(32'(c >= WDT - 2 && c <= WDT + 4), 32'h1);
    apb(0, `SWWC_ADDR_STATUS, 0);
    chk(rd, 32'h08);
    apb(1, `SWWC_ADDR_OPTION, 32'h0f);
    pulse(1'b1, 13'h0);
    // an enabled flag already pending turns sleep into a no-operation
    apb(1, `SWWC_ADDR_WAKE_EN, 32'h1);
    @(posedge clk_sys);
    irqFlag <= 9'h1;
    pulse(1'b0, 13'h200);
    chk({30'h0, phaseClkEn, prefetchValid}, 32'h2);
    apb(0, `SWWC_ADDR_STATUS, 0);
    chk(rd, 32'h08);
    @(posedge clk_sys);
    irqFlag <= 9'h0;
    // master clear during sleep resets rather than wakes
    goSleep(13'h300);
    sawRst = 1'b0;
    sawWake = 1'b0;
    @(posedge clk_sys);
    masterClearN <= 1'b0;
    @(posedge clk_sys);
    masterClearN <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk({29'h0, sawRst, sawWake, phaseClkEn}, 32'h5);
    // second reset with the watchdog fuse off: no timeout may wake or reset
    @(posedge clk_sys);
    cfgWord <= 8'h00;
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    apb(0, `SWWC_ADDR_STATUS, 0);
    chk(rd, 32'h18);
    apb(1, `SWWC_ADDR_OPTION, 32'h08);
    goSleep(13'h400);
    sawRst = 1'b0;
    repeat (3 * WDT) @(posedge clk_sys);
    #1;
    chk({30'h0, sawRst, phaseClkEn}, 32'h0);
    complete_run();
  end
endmodule
